/* logic/cgm_ctl.sv */
// Clock generator mode sequencing, filter and trim registers
// What this block does
// (R1) Stable flag after three in-window toggling samples
// (R2) Off state clears stable flag
// (R3) Self-clocked loss watch waits for stability
// (R4) Twelve-bit filter, upper write commits in 00
// (R5) Upper write ignored while latch busy
// (R6) Trim code scales reference period binary
// (R7) Stop normally halts clocks, goes off
// (R8) Debug enabled keeps clocks during stop
// (R9) Keep-in-stop runs generators, gates feed
// (R10) Interrupt wake keeps settings, engaged-ext uses internal
// (R11) Interrupt wake bypassed-ext holds output off
// (R12) Reset wake restores defaults, keeps trim
// (R13) Crystal needs 4096 reference edges first
// (R14) Self-clocked after reset, off exit (except irq wake to bypassed-ext), X1-to-00
// (R15) Missing external reference falls back self-clocked
// (R16) Self-clocked: loop open, output osc over divider
// (R17) Reset loads default filter; internal keeps frequency
// (R18) From engaged-ext keep frequency, drop halving
// (R19) Off exit resumes previous oscillator frequency
// (R20) Off exit with X1 closes loop when stable
// (R21) Two-bit mode report encoding
// (R22) Engaged internal on write 01 or stable
// (R23) Software writes lower filter before upper
// (R24) Registers eight bits, unused bits zero
`timescale 1ns/1ps
`include "cgm_params.svh"
module cgm_ctl
  import cgm_pkg::*;
#(
  parameter int FLT_W = 12,
  parameter int TRM_W = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [2:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic             stop_req,
  input  wire logic             wake_irq,
  input  wire logic             wake_rst,
  input  wire logic             debug_enable,
  input  wire logic             crystal_ref,
  input  wire logic             ref_clk_edge,
  input  wire logic             ext_ref_valid_flag,
  input  wire logic             clock_loss_flag,
  input  wire logic             loop_locked,
  input  wire logic signed [7:0] count_error,
  input  wire logic             sample_strobe,
  input  wire logic             osc_toggling,
  output logic                  osc_stable_flag,
  output logic                  off_state,
  output logic                  generators_run,
  output logic                  mcu_clock_feed,
  output logic                  gen_out_enable,
  output logic                  use_internal_ref,
  output logic                  loss_watch_en,
  output logic                  loop_closed,
  output logic                  halve_output,
  output logic      [2:0]       out_div_code,
  output logic      [FLT_W-1:0] loop_filter_value,
  output logic      [TRM_W-1:0] ref_period_trim,
  output logic                  ext_ref_engaged,
  output logic      [1:0]       clock_mode_report
);

  cgm_mode_e  mode_q;
  logic [1:0] clock_mode_select_q;
  logic [2:0] rfd_q;
  logic       osc_keep_in_stop_q;
  logic [FLT_W-1:0] flt_q;
  logic [7:0] flt_low_q;
  logic       latch_busy_q;
  logic [TRM_W-1:0] trim_q;
  logic       off_q;
  logic       stable_q;
  logic [1:0] samp_cnt_q;
  logic signed [7:0] last_err_q;
  logic       waking_q;
  logic       unlocked_q;
  logic [12:0] xtal_cnt_q;
  logic       xtal_ready_q;
  logic [7:0] rdata_d;

  // Magnitude of the change between two error samples
  function automatic logic [7:0] err_delta(input logic signed [7:0] a,
                                            input logic signed [7:0] b);
    logic signed [8:0] d;
    d = 9'(a) - 9'(b);
    return d[8] ? 8'(-d) : 8'(d);
  endfunction

  wire wr_ctl   = reg_wr && reg_addr == `CGM_OFF_CONTROL;
  wire wr_upper = reg_wr && reg_addr == `CGM_OFF_FLT_UPPER;
  wire wr_lower = reg_wr && reg_addr == `CGM_OFF_FLT_LOWER;
  wire [1:0] new_sel = reg_wdata[`CGM_CTL_MODE_LSB +: 2];
  // Stop with neither debug nor keep-in-stop turns everything off
  wire go_off = stop_req && !debug_enable && !osc_keep_in_stop_q;
  wire wake   = off_q && (wake_irq || wake_rst);

  // (R1) Stability qualification
  always_ff @(posedge clk_sys) begin
    if (!rst_n || go_off) begin
      // (R2) Off clears stable
      stable_q   <= 1'b0;
      samp_cnt_q <= 2'h0;
      last_err_q <= 8'sh00;
    end else if (sample_strobe) begin
      last_err_q <= count_error;
      if (osc_toggling &&
          err_delta(count_error, last_err_q) <= `CGM_UNLOCK_WIN) begin
        if (samp_cnt_q != `CGM_STABLE_SAMPLES)
          samp_cnt_q <= samp_cnt_q + 2'h1;
        else
          stable_q <= 1'b1;
      end else begin
        samp_cnt_q <= 2'h0;
        stable_q   <= 1'b0;
      end
    end
  end

  // Control register: mode select, divider, keep-in-stop
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (wake && wake_rst)) begin
      // (R12) Reset defaults restored
      clock_mode_select_q <= 2'h0;
      rfd_q               <= `CGM_RFD_RESET;
      osc_keep_in_stop_q  <= 1'b0;
    end else if (wr_ctl) begin
      clock_mode_select_q <= new_sel;
      rfd_q               <= reg_wdata[`CGM_CTL_RFD_LSB +: 3];
      osc_keep_in_stop_q  <= reg_wdata[`CGM_CTL_KEEP_BIT];
    end else if (mode_q != CGM_SELF_CLOCKED &&
                 clock_mode_select_q[1] && !ext_ref_valid_flag &&
                 clock_loss_flag) begin
      clock_mode_select_q <= 2'h0;
    end
  end

  // (R7) Off state entry and exit
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      off_q    <= 1'b0;
      waking_q <= 1'b0;
    end else if (go_off) begin
      off_q    <= 1'b1;
    end else if (wake) begin
      off_q    <= 1'b0;
      // (R10) Interrupt wake marks recovery
      waking_q <= wake_irq && !wake_rst;
    end else if (xtal_ready_q || !crystal_ref) begin
      waking_q <= 1'b0;
    end
  end

  // (R13) Crystal start count
  always_ff @(posedge clk_sys) begin
    if (!rst_n || off_q) begin
      xtal_cnt_q   <= 13'h0;
      xtal_ready_q <= 1'b0;
    end else if (ref_clk_edge && !xtal_ready_q) begin
      xtal_cnt_q <= xtal_cnt_q + 13'h1;
      if (xtal_cnt_q + 13'h1 == `CGM_XTAL_COUNT)
        xtal_ready_q <= 1'b1;
    end
  end

  wire ext_ok = ext_ref_valid_flag && (xtal_ready_q || !crystal_ref);

  // Mode sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // (R14) Reset enters self-clocked
      mode_q     <= CGM_SELF_CLOCKED;
      unlocked_q <= 1'b0;
    end else if (wake) begin
      // (R14) Off exit to self-clocked, or bypassed-ext on irq wake with select 10
      if (!wake_rst && clock_mode_select_q == 2'h2 && ext_ref_valid_flag)
        mode_q <= CGM_BYPASSED_EXT;
      else
        mode_q <= CGM_SELF_CLOCKED;
    end else if (!off_q) begin
      unlocked_q <= !loop_locked;
      if (clock_mode_select_q[1] && !ext_ref_valid_flag &&
          clock_loss_flag) begin
        // (R15) Fallback on lost reference
        mode_q <= CGM_SELF_CLOCKED;
      end else if (wr_ctl && new_sel == 2'h1) begin
        // (R22) Written 01
        mode_q <= CGM_ENGAGED_INT;
      end else if (wr_ctl && new_sel == 2'h0) begin
        // (R14) Rewrite to 00
        mode_q <= CGM_SELF_CLOCKED;
      end else if (mode_q == CGM_SELF_CLOCKED) begin
        // (R20) Close loop once stable
        if (clock_mode_select_q == 2'h1 && stable_q)
          mode_q <= CGM_ENGAGED_INT;
        else if (clock_mode_select_q == 2'h3 && stable_q && ext_ok)
          mode_q <= CGM_ENGAGED_EXT;
        else if (clock_mode_select_q == 2'h2 && ext_ok)
          mode_q <= CGM_BYPASSED_EXT;
      end else if (mode_q == CGM_ENGAGED_EXT && clock_loss_flag &&
                   ext_ref_valid_flag) begin
        mode_q <= CGM_BYPASSED_EXT;
      end
    end
  end

  // (R4) Filter commit on upper write
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (wake && wake_rst)) begin
      // (R17) Default filter on reset
      flt_q        <= `CGM_FLT_RESET;
      flt_low_q    <= 8'h00;
      latch_busy_q <= 1'b0;
    end else begin
      latch_busy_q <= 1'b0;
      if (wr_lower && clock_mode_select_q == 2'h0)
        // (R23) Lower staged first
        flt_low_q <= reg_wdata;
      // (R5) Busy latch ignores write
      if (wr_upper && clock_mode_select_q == 2'h0 && !latch_busy_q) begin
        flt_q        <= {reg_wdata[3:0], flt_low_q};
        latch_busy_q <= 1'b1;
      end
    end
  end

  // (R6) Trim, preserved across reset wake
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      trim_q <= `CGM_TRIM_RESET;
    else if (reg_wr && reg_addr == `CGM_OFF_TRIM)
      trim_q <= reg_wdata;
  end

  // (R24) Eight-bit read, zeros elsewhere
  always_comb begin
    unique case (reg_addr)
      `CGM_OFF_STATUS:      rdata_d = {7'h00, stable_q};
      `CGM_OFF_FLT_UPPER:   rdata_d = {4'h0, flt_q[11:8]};
      `CGM_OFF_FLT_LOWER:   rdata_d = flt_q[7:0];
      `CGM_OFF_TRIM:        rdata_d = trim_q;
      `CGM_OFF_CONTROL:     rdata_d = {2'h0, osc_keep_in_stop_q, rfd_q,
                                       clock_mode_select_q};
      `CGM_OFF_MODE_REPORT: rdata_d = {6'h00, mode_q};
      default:              rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= 8'h00;
  end

  assign osc_stable_flag   = stable_q;
  assign off_state         = off_q;
  assign loop_filter_value = flt_q;
  assign ref_period_trim   = trim_q;
  assign out_div_code      = rfd_q;
  // (R21) Mode report
  assign clock_mode_report = mode_q;
  // (R8) Debug keeps generators; (R9) keep-in-stop gates feed only
  assign generators_run = !off_q;
  assign mcu_clock_feed = !off_q && !(stop_req && !debug_enable);
  // (R3) In self-clocked, watch loss only when stable
  assign loss_watch_en = (mode_q != CGM_SELF_CLOCKED) || stable_q;
  // (R16) Loop open in self-clocked
  assign loop_closed = mode_q == CGM_ENGAGED_INT ||
                       mode_q == CGM_ENGAGED_EXT;
  // (R18) Halving only while engaged-ext unlocked; (R19) filter held
  assign halve_output = mode_q == CGM_ENGAGED_EXT && unlocked_q;
  // (R10) Internal source until external ready
  assign use_internal_ref = waking_q && clock_mode_select_q == 2'h3;
  assign ext_ref_engaged  = ext_ok && mode_q != CGM_SELF_CLOCKED;
  // (R11) Output held for bypassed wake
  assign gen_out_enable = !off_q &&
                          !(waking_q && clock_mode_select_q == 2'h2);

  property p_off_clears;
    @(posedge clk_sys) disable iff (!rst_n)
      go_off |=> !osc_stable_flag;
  endproperty
  a_off_clears: assert property (p_off_clears) // (R2)
    else $error("stable flag not cleared in off");

  property p_report;
    @(posedge clk_sys) disable iff (!rst_n)
      go_off |=> off_state && !generators_run;
  endproperty
  a_report: assert property (p_report) // (R7)
    else $error("generators run while off");

  property p_fallback;
    @(posedge clk_sys) disable iff (!rst_n)
      !off_q && !wake && clock_mode_select_q[1] && !ext_ref_valid_flag &&
      clock_loss_flag |=> clock_mode_report == 2'h0;
  endproperty
  a_fallback: assert property (p_fallback) // (R15)
    else $error("no fallback on lost reference");

  property p_busy;
    @(posedge clk_sys) disable iff (!rst_n)
      latch_busy_q |=> $stable(loop_filter_value);
  endproperty
  a_busy: assert property (p_busy) // (R5)
    else $error("filter changed while latch busy");

  property p_ro;
    @(posedge clk_sys) disable iff (!rst_n)
      clock_mode_select_q != 2'h0 && !(wake && wake_rst)
      |=> $stable(loop_filter_value);
  endproperty
  a_ro: assert property (p_ro) // (R4)
    else $error("filter written outside self-clocked");

  property p_watch;
    @(posedge clk_sys) disable iff (!rst_n)
      clock_mode_report == 2'h0 && !osc_stable_flag |-> !loss_watch_en;
  endproperty
  a_watch: assert property (p_watch) // (R3)
    else $error("loss watched before stable");

  property p_feed;
    @(posedge clk_sys) disable iff (!rst_n)
      stop_req && !debug_enable |-> !mcu_clock_feed;
  endproperty
  a_feed: assert property (p_feed) // (R9)
    else $error("feed on during stop");

  property p_open;
    @(posedge clk_sys) disable iff (!rst_n)
      clock_mode_report == 2'h0 |-> !loop_closed && !halve_output;
  endproperty
  a_open: assert property (p_open) // (R16)
    else $error("loop closed in self-clocked");

  property p_debug;
    @(posedge clk_sys) disable iff (!rst_n)
      debug_enable && !off_state |=> !off_state;
  endproperty
  a_debug: assert property (p_debug) // (R8)
    else $error("debug stop turned clocks off");

  property p_keep;
    @(posedge clk_sys) disable iff (!rst_n)
      osc_keep_in_stop_q && !off_state |=> generators_run;
  endproperty
  a_keep: assert property (p_keep) // (R9)
    else $error("keep-in-stop lost generators");

  property p_stable_set;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(osc_stable_flag) |-> $past(sample_strobe) && $past(osc_toggling);
  endproperty
  a_stable_set: assert property (p_stable_set) // (R1)
    else $error("stable flag set without a toggling sample");

  // Self-clocked, waiting to close onto the internal reference
  sequence s_ready_to_close;
    clock_mode_report == 2'h0 && clock_mode_select_q == 2'h1 &&
      osc_stable_flag && !off_state && !wr_ctl;
  endsequence

  property p_auto_close;
    @(posedge clk_sys) disable iff (!rst_n)
      s_ready_to_close |=> clock_mode_report == 2'h1;
  endproperty
  a_auto_close: assert property (p_auto_close) // (R20)
    else $error("loop not closed once stable");

endmodule // cgm_ctl

/* logic/cgm_params.svh */
// Constants for the clock generator mode and filter control block
`ifndef CGM_PARAMS_SVH
`define CGM_PARAMS_SVH
`define CGM_OFF_STATUS      3'h0
`define CGM_OFF_FLT_UPPER   3'h1
`define CGM_OFF_FLT_LOWER   3'h2
`define CGM_OFF_TRIM        3'h3
`define CGM_OFF_CONTROL     3'h4
`define CGM_OFF_MODE_REPORT 3'h5
`define CGM_FLT_RESET       12'h200
`define CGM_TRIM_RESET      8'h80
`define CGM_RFD_RESET       3'h1
`define CGM_XTAL_COUNT      13'h1000
`define CGM_STABLE_SAMPLES  2'h2
`define CGM_UNLOCK_WIN      8'h10
`define CGM_CTL_MODE_LSB    0
`define CGM_CTL_RFD_LSB     2
`define CGM_CTL_KEEP_BIT    5
`endif

/* logic/cgm_pkg.sv */
// Types shared by the clock generator mode and filter control block
package cgm_pkg;
  typedef enum logic [1:0] {
    CGM_SELF_CLOCKED  = 2'h0,
    CGM_ENGAGED_INT   = 2'h1,
    CGM_BYPASSED_EXT  = 2'h2,
    CGM_ENGAGED_EXT   = 2'h3
  } cgm_mode_e;
endpackage

/* testbench/cgm_osc_model.sv */
// Oscillator and reference model feeding the generator's sensing inputs
`timescale 1ns/1ps
module cgm_osc_model (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         run,
  input  wire logic         big_err,
  input  wire logic         ext_ok,
  input  wire logic         lost,
  output logic              ref_clk_edge,
  output logic signed [7:0] count_error,
  output logic              sample_strobe,
  output logic              osc_toggling,
  output logic              ext_ref_valid_flag,
  output logic              clock_loss_flag,
  output logic              loop_locked
);
  logic [3:0] tick_q;
  assign osc_toggling = run;
  assign ext_ref_valid_flag = ext_ok;
  assign clock_loss_flag = lost;
  assign loop_locked = run && !big_err;
  // Error word only holds at a strobe; it scrambles between samples
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      tick_q <= 4'h0;
      sample_strobe <= 1'b0;
      ref_clk_edge <= 1'b0;
      count_error <= 8'sh00;
    end else begin
      tick_q <= tick_q + 4'h1;
      sample_strobe <= run && (tick_q[1:0] == 2'h3);
      ref_clk_edge <= ext_ok && tick_q[0];
      if (tick_q[1:0] == 2'h3) begin
        if (big_err) begin
          count_error <= tick_q[2] ? 8'sh60 : -8'sh60;
        end else begin
          count_error <= {6'h00, tick_q[3:2]};
        end
      end else begin
        count_error <= ~count_error;
      end
    end
  end
endmodule // cgm_osc_model

/* testbench/cgm_ctl_tb.sv */
// Self-checking bench for the clock generator mode and filter control
`timescale 1ns/1ps
module cgm_ctl_tb;
  import cgm_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0, out_div_code;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, ref_period_trim, d, s, lo, hi;
  logic reg_wr = 1'b0, reg_rd = 1'b0, stop_req = 1'b0, wake_irq = 1'b0;
  logic wake_rst = 1'b0, debug_enable = 1'b0, run = 1'b0, big_err = 1'b1;
  logic ext_ok = 1'b1, lost = 1'b0, ref_clk_edge, sample_strobe;
  logic xtal = 1'b0;
  logic osc_toggling, ext_ref_valid_flag, clock_loss_flag, loop_locked;
  logic signed [7:0] count_error;
  logic osc_stable_flag, off_state, generators_run, mcu_clock_feed;
  logic gen_out_enable, use_internal_ref, loss_watch_en, loop_closed;
  logic halve_output, ext_ref_engaged;
  logic [11:0] loop_filter_value;
  logic [1:0] clock_mode_report;
  logic [7:0] rst_tab [8] = '{8'h00, 8'h02, 8'h00, 8'h80,
                              8'h04, 8'h00, 8'h00, 8'h00};
  int fails = 0, total_checks = 0;
  always #50 clk_sys = ~clk_sys;
  cgm_osc_model osc (.clk_sys(clk_sys), .rst_n(rst_n), .run(run),
    .big_err(big_err), .ext_ok(ext_ok), .lost(lost),
    .ref_clk_edge(ref_clk_edge), .count_error(count_error),
    .sample_strobe(sample_strobe), .osc_toggling(osc_toggling),
    .ext_ref_valid_flag(ext_ref_valid_flag),
    .clock_loss_flag(clock_loss_flag), .loop_locked(loop_locked));
  cgm_ctl uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .stop_req(stop_req), .wake_irq(wake_irq),
    .wake_rst(wake_rst), .debug_enable(debug_enable), .crystal_ref(xtal),
    .ref_clk_edge(ref_clk_edge), .ext_ref_valid_flag(ext_ref_valid_flag),
    .clock_loss_flag(clock_loss_flag), .loop_locked(loop_locked),
    .count_error(count_error), .sample_strobe(sample_strobe),
    .osc_toggling(osc_toggling), .osc_stable_flag(osc_stable_flag),
    .off_state(off_state), .generators_run(generators_run),
    .mcu_clock_feed(mcu_clock_feed), .gen_out_enable(gen_out_enable),
    .use_internal_ref(use_internal_ref), .loss_watch_en(loss_watch_en),
    .loop_closed(loop_closed), .halve_output(halve_output),
    .out_div_code(out_div_code), .loop_filter_value(loop_filter_value),
    .ref_period_trim(ref_period_trim), .ext_ref_engaged(ext_ref_engaged),
    .clock_mode_report(clock_mode_report));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Write strobe stays up so writes can run back to back
  task automatic bus_wr(logic [2:0] a, logic [7:0] v);
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
  endtask
  task automatic wt(int n);
    reg_wr <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic bus_rd(logic [2:0] a, output logic [7:0] v);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    // Read data stand only until the next edge; take them there
    @(posedge clk_sys);
    v = reg_rdata;
  endtask
  task automatic wait_stable();
    int i;
    i = 0;
    while (osc_stable_flag !== 1'b1 && i < 300) begin
      wt(1);
      i++;
    end
    chk("stable flag", {15'h0, osc_stable_flag}, 16'h1);
  endtask
  // Two full crystal counts dominate the run time
  initial begin
    repeat (25000) @(posedge clk_sys);
    fails++;
    final_report();
  end
  initial begin
    s = 8'h35;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    wt(1);
    for (int a = 0; a < 8; a++) begin
      bus_rd(a[2:0], d);
      chk("reset read", {8'h0, d}, {8'h0, rst_tab[a]});
    end
    chk("div code", {13'h0, out_div_code}, 16'h1);
    for (int i = 0; i < 4; i++) begin
      s = lfsr(s);
      lo = s;
      s = lfsr(s);
      hi = s;
      bus_wr(3'h2, lo);
      bus_wr(3'h1, hi);
      bus_wr(3'h1, ~hi);
      bus_rd(3'h1, d);
      chk("filter", {4'h0, loop_filter_value}, {4'h0, hi[3:0], lo});
      chk("upper read", {8'h0, d}, {12'h0, hi[3:0]});
    end
    s = lfsr(s);
    bus_wr(3'h3, s);
    bus_rd(3'h3, d);
    chk("trim read", {8'h0, d}, {8'h0, s});
    chk("trim out", {8'h0, ref_period_trim}, {8'h0, s});
    run <= 1'b1;
    wt(40);
    chk("unstable", {15'h0, osc_stable_flag}, 16'h0);
    chk("watch off", {15'h0, loss_watch_en}, 16'h0);
    big_err <= 1'b0;
    wait_stable();
    chk("watch on", {15'h0, loss_watch_en}, 16'h1);
    bus_wr(3'h4, 8'h05);
    wt(4);
    chk("mode int", {14'h0, clock_mode_report}, 16'h1);
    chk("closed int", {15'h0, loop_closed}, 16'h1);
    chk("no halve int", {15'h0, halve_output}, 16'h0);
    bus_wr(3'h2, 8'hAA);
    bus_wr(3'h1, 8'h0F);
    wt(2);
    chk("ro filter", {4'h0, loop_filter_value}, {4'h0, hi[3:0], lo});
    stop_req <= 1'b1;
    run <= 1'b0;
    wt(4);
    chk("off", {15'h0, off_state}, 16'h1);
    chk("off feed", {15'h0, mcu_clock_feed}, 16'h0);
    chk("off stable", {15'h0, osc_stable_flag}, 16'h0);
    chk("off out", {15'h0, gen_out_enable}, 16'h0);
    stop_req <= 1'b0;
    wake_irq <= 1'b1;
    wt(1);
    wake_irq <= 1'b0;
    wt(3);
    chk("wake self", {14'h0, clock_mode_report}, 16'h0);
    chk("open self", {15'h0, loop_closed}, 16'h0);
    chk("feed back", {15'h0, mcu_clock_feed}, 16'h1);
    bus_rd(3'h4, d);
    chk("kept ctl", {8'h0, d}, 16'h05);
    run <= 1'b1;
    wait_stable();
    wt(4);
    chk("auto int", {14'h0, clock_mode_report}, 16'h1);
    debug_enable <= 1'b1;
    stop_req <= 1'b1;
    wt(4);
    chk("debug on", {15'h0, off_state}, 16'h0);
    chk("debug feed", {15'h0, mcu_clock_feed}, 16'h1);
    stop_req <= 1'b0;
    debug_enable <= 1'b0;
    bus_wr(3'h4, 8'h25);
    stop_req <= 1'b1;
    wt(4);
    chk("keep gen", {15'h0, generators_run}, 16'h1);
    chk("keep feed", {15'h0, mcu_clock_feed}, 16'h0);
    stop_req <= 1'b0;
    bus_wr(3'h4, 8'h05);
    stop_req <= 1'b1;
    wt(4);
    stop_req <= 1'b0;
    wake_rst <= 1'b1;
    wt(1);
    wake_rst <= 1'b0;
    wt(3);
    bus_rd(3'h4, d);
    chk("rst ctl", {8'h0, d}, 16'h04);
    bus_rd(3'h3, d);
    chk("rst trim", {8'h0, d}, {8'h0, s});
    chk("rst mode", {14'h0, clock_mode_report}, 16'h0);
    chk("rst filt", {4'h0, loop_filter_value}, 16'h200);
    bus_wr(3'h4, 8'h0E);
    wt(4);
    chk("bypass", {14'h0, clock_mode_report}, 16'h2);
    chk("ext engaged", {15'h0, ext_ref_engaged}, 16'h1);
    ext_ok <= 1'b0;
    lost <= 1'b1;
    wt(4);
    chk("fallback", {14'h0, clock_mode_report}, 16'h0);
    chk("fallback ext", {15'h0, ext_ref_engaged}, 16'h0);
    bus_rd(3'h4, d);
    chk("fallback ctl", {8'h0, d}, 16'h0C);
    chk("div code", {13'h0, out_div_code}, 16'h3);
    xtal <= 1'b1;
    ext_ok <= 1'b1;
    lost <= 1'b0;
    bus_wr(3'h4, 8'h0E);
    wt(4);
    chk("xtal wait", {14'h0, clock_mode_report}, 16'h0);
    wt(8300);
    chk("xtal done", {14'h0, clock_mode_report}, 16'h2);
    chk("xtal engaged", {15'h0, ext_ref_engaged}, 16'h1);
    stop_req <= 1'b1;
    wt(4);
    stop_req <= 1'b0;
    wake_irq <= 1'b1;
    wt(1);
    wake_irq <= 1'b0;
    wt(3);
    chk("byp wake", {14'h0, clock_mode_report}, 16'h2);
    chk("byp held", {15'h0, gen_out_enable}, 16'h0);
    wt(8300);
    chk("byp out", {15'h0, gen_out_enable}, 16'h1);
    bus_wr(3'h4, 8'h0C);
    bus_wr(3'h4, 8'h0F);
    wt(4);
    chk("mode ext", {14'h0, clock_mode_report}, 16'h3);
    big_err <= 1'b1;
    wt(2);
    chk("halve", {15'h0, halve_output}, 16'h1);
    stop_req <= 1'b1;
    wt(4);
    stop_req <= 1'b0;
    wake_irq <= 1'b1;
    wt(1);
    wake_irq <= 1'b0;
    wt(3);
    chk("int ref", {15'h0, use_internal_ref}, 16'h1);
    chk("ext wake self", {14'h0, clock_mode_report}, 16'h0);
    chk("no halve", {15'h0, halve_output}, 16'h0);
    final_report();
  end
endmodule // cgm_ctl_tb
